// ==== core/sdis_core.sv ====
// memory-side power-up and self-refresh sequencer
// assumes the controller drives all pins synchronously to ref_clk
`timescale 1ns/1ns
module sdis_core (
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    input  wire sdis_pkg::sdis_pins_type pins,
    output logic                      initDone_q,
    output logic                      selfRefresh_q,
    output logic                      refreshTick_q,
    output logic [sdis_pkg::ROW_W-1:0] refreshRow_q,
    output logic                      dqHighZ_q
);
    import sdis_pkg::*;

    // command decode from the sampled pins
    function automatic sdis_cmd_type decodeCmd(input sdis_pins_type p);
        sdis_cmd_type c;
        c = CMD_OTHER;
        if (p.csN) begin
            c = CMD_DESELECT;
        end else if (!p.rasN && !p.casN && !p.cke && p.weN) begin
            c = CMD_SELF_REFRESH;
        end else if (!p.rasN && !p.casN && p.weN) begin
            c = CMD_AUTO_REFRESH;
        end else if (!p.rasN && !p.casN && !p.weN) begin
            c = CMD_MODE_SET;
        end else if (!p.rasN && p.casN && !p.weN && p.a10) begin
            c = CMD_PRECHARGE_ALL;
        end else if (p.rasN && p.casN && p.weN) begin
            c = CMD_NO_OPERATION;
        end
        return c;
    endfunction

    sdis_state_type             state_q;      // sequencer state
    sdis_state_type             state_d;      // next state
    logic [1:0]                 initRef_q;    // init refreshes seen
    logic [1:0]                 initRef_d;    // next init refresh count
    logic [REFRESH_CNT_W-1:0]   tickCnt_q;    // self-refresh interval timer
    logic [REFRESH_CNT_W-1:0]   tickCnt_d;    // next timer value
    logic [ROW_W-1:0]           refreshRow_d; // next row to refresh
    logic                       tickNow;      // interval elapsed this cycle

    // decoded command, only trusted outside self-refresh
    wire sdis_cmd_type cmd      = decodeCmd(pins);
    wire logic isPrechargeAll   = (cmd == CMD_PRECHARGE_ALL);
    wire logic isModeSet        = (cmd == CMD_MODE_SET);
    wire logic isAutoRefresh    = (cmd == CMD_AUTO_REFRESH) && pins.cke;
    wire logic isSelfEntry      = (cmd == CMD_SELF_REFRESH);
    wire logic inSelf           = (state_q == ST_SELF_REFRESH);
    wire logic lastInitRef      = (initRef_q == INIT_REF_LAST);

    // next-state selection
    always_comb begin
        state_d   = state_q;
        initRef_d = initRef_q;
        case (state_q)
            // wait for cke to rise after supplies come up
            ST_POWER_UP: begin
                if (pins.cke) begin
                    state_d = ST_PRECHARGE_WAIT;
                end
            end
            // every bank must be precharged first
            ST_PRECHARGE_WAIT: begin
                if (pins.cke && isPrechargeAll) begin
                    state_d = ST_MODE_WAIT;
                end
            end
            // mode register gets its initial contents
            ST_MODE_WAIT: begin
                if (pins.cke && isModeSet) begin
                    state_d = ST_REFRESH_WAIT;
                end
            end
            // count the settling auto-refresh cycles
            ST_REFRESH_WAIT: begin
                if (isAutoRefresh) begin
                    initRef_d = initRef_q + 2'h1;
                    if (lastInitRef) begin
                        state_d = ST_READY;
                    end
                end
            end
            // normal operation, watch for self-refresh entry
            ST_READY: begin
                if (isSelfEntry) begin
                    state_d = ST_SELF_REFRESH;
                end
            end
            // only cke is looked at here
            ST_SELF_REFRESH: begin
                if (pins.cke) begin
                    state_d = ST_READY;
                end
            end
            default: begin
                state_d = ST_POWER_UP;
            end
        endcase
    end

    // internal refresh timer and row address while self-refreshing
    assign tickNow = inSelf && (tickCnt_q == REFRESH_LAST);
    always_comb begin
        tickCnt_d    = tickCnt_q;
        refreshRow_d = refreshRow_q;
        if (!inSelf) begin
            tickCnt_d = '0;
        end else if (tickNow) begin
            tickCnt_d    = '0;
            refreshRow_d = refreshRow_q + ROW_W'(1);
        end else begin
            tickCnt_d = tickCnt_q + REFRESH_CNT_W'(1);
        end
    end

    // state and counters
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q   <= ST_POWER_UP;
            initRef_q <= 2'h0;
            tickCnt_q <= '0;
        end else begin
            state_q   <= state_d;
            initRef_q <= initRef_d;
            tickCnt_q <= tickCnt_d;
        end
    end

    // registered outputs
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            initDone_q    <= 1'b0;
            selfRefresh_q <= 1'b0;
            refreshTick_q <= 1'b0;
            refreshRow_q  <= '0;
            dqHighZ_q     <= 1'b1;
        end else begin
            initDone_q    <= (state_d == ST_READY) || (state_d == ST_SELF_REFRESH);
            selfRefresh_q <= (state_d == ST_SELF_REFRESH);
            refreshTick_q <= tickNow;
            refreshRow_q  <= refreshRow_d;
            // data lines stay released while masked or while the next state is not ready
            dqHighZ_q     <= pins.dqm || (state_d != ST_READY);
        end
    end

    // ---- checks ----
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // entry command while ready
    sequence selfEnter_s;
        state_q == ST_READY && !pins.cke && !pins.csN && !pins.rasN && !pins.casN && pins.weN;
    endsequence
    // residency with cke low
    sequence selfStay_s;
        selfRefresh_q && !pins.cke;
    endsequence

    // mask high always releases the data lines next cycle
    dq_highz_a: assert property (pins.dqm |=> dqHighZ_q)
        else $error("data lines driven while masked");

    // entry decode takes effect one cycle later
    sref_entry_a: assert property (selfEnter_s |=> selfRefresh_q ##1 (selfRefresh_q || $past(pins.cke)))
        else $error("self-refresh entry not taken");

    // commands on other pins are ignored during self-refresh
    sref_ignore_a: assert property (
        selfStay_s and (pins.csN == 1'b0) |=> selfRefresh_q && initDone_q && !dqHighZ_q == 1'b0)
        else $error("command acted on during self-refresh");

    // residency persists while cke is low
    sref_hold_a: assert property (selfStay_s |=> selfRefresh_q)
        else $error("self-refresh left with cke low");

    // cke high ends residency on the next edge
    sref_exit_a: assert property (selfRefresh_q && pins.cke |=> !selfRefresh_q && initDone_q)
        else $error("self-refresh exit not taken");

    // internal refresh fires within one interval of residency
    sref_tick_a: assert property (
        $rose(selfRefresh_q) ##0 (selfRefresh_q && !pins.cke) [*1] |-> ##[1:780] (refreshTick_q || !selfRefresh_q))
        else $error("no internal refresh in interval");

    // second init refresh completes initialization
    init_done_a: assert property (
        state_q == ST_REFRESH_WAIT && isAutoRefresh && lastInitRef |=> initDone_q && !selfRefresh_q)
        else $error("init not complete after refreshes");

    // mode set only counts after a precharge-all
    init_order_a: assert property (
        state_q == ST_PRECHARGE_WAIT && isModeSet && !isPrechargeAll |=> !initDone_q)
        else $error("init order violated");

    // internal refresh pulse lasts one cycle only
    tick_pulse_a: assert property (refreshTick_q |=> !refreshTick_q)
        else $error("refresh pulse longer than one cycle");

    // each internal refresh moves on to the next row
    row_step_a: assert property (
        refreshTick_q |-> refreshRow_q == $past(refreshRow_q) + ROW_W'(1))
        else $error("refresh row did not advance");

    // no residency before initialization has completed
    self_init_a: assert property (!initDone_q |-> !selfRefresh_q)
        else $error("self-refresh without init");

    // entry pattern before ready is refused
    early_entry_a: assert property (
        state_q != ST_READY && !inSelf && isSelfEntry |=> !selfRefresh_q)
        else $error("early self-refresh entry taken");

    // data lines stay released during residency
    self_highz_a: assert property (selfRefresh_q |-> dqHighZ_q)
        else $error("data lines driven in self-refresh");

endmodule // sdis_core

// ==== inc/sdis_pkg.sv ====
// package for the sdram power-up and self-refresh sequencer
// assumes one clock (ref_clk, 50 MHz) on which the controller drives all pins
// Contract
// - mask high keeps data lines high impedance
// - when ready, cs, ras, cas low and we high with cke low enters
// - one cycle after entry only cke matters
// - stays in self-refresh while cke low
package sdis_pkg;

    // clock rate
    localparam int CLK_PERIOD_NS        = 20;
    // internal refresh spacing during self-refresh, longest time rounds down
    localparam int REFRESH_INTERVAL_NS  = 15600;
    localparam int REFRESH_CYCLES       = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
    localparam int REFRESH_CNT_W        = 10;
    // rows refreshed by one full sweep
    localparam int REFRESH_ROWS         = 4096;
    localparam int ROW_W                = 12;
    // auto-refresh cycles that finish initialization
    localparam int INIT_REFRESH_COUNT   = 2;
    localparam logic [1:0] INIT_REF_LAST = 2'(INIT_REFRESH_COUNT - 1);
    localparam logic [REFRESH_CNT_W-1:0] REFRESH_LAST = REFRESH_CNT_W'(REFRESH_CYCLES - 1);

    // command pins as sampled on a rising clock edge
    typedef struct packed {
        logic cke;      // clock enable pin
        logic csN;      // chip select
        logic rasN;     // row strobe
        logic casN;     // column strobe
        logic weN;      // write enable
        logic dqm;      // data mask
        logic a10;      // address bit 10, all-banks select
    } sdis_pins_type;

    // decoded commands
    typedef enum logic [2:0] {
        CMD_NO_OPERATION,
        CMD_DESELECT,
        CMD_PRECHARGE_ALL,
        CMD_MODE_SET,
        CMD_AUTO_REFRESH,
        CMD_SELF_REFRESH,
        CMD_OTHER
    } sdis_cmd_type;

    // sequencer states
    typedef enum logic [2:0] {
        ST_POWER_UP,
        ST_PRECHARGE_WAIT,
        ST_MODE_WAIT,
        ST_REFRESH_WAIT,
        ST_READY,
        ST_SELF_REFRESH
    } sdis_state_type;

endpackage

// ==== testbench/sdis_ctrl_model.sv ====
// controller-side model driving the memory command pins
// assumes the bench supplies ref_clk and calls these tasks
`timescale 1ns/1ns
module sdis_ctrl_model #(
    parameter int STABLE_CYCLES = 10000 // clock settle span, 200 us at 20 ns
) (
    input  wire logic                    ref_clk,
    output sdis_pkg::sdis_pins_type      pins
);
    import sdis_pkg::*;
    // command encodings {cke,csN,rasN,casN,weN,dqm,a10}
    localparam sdis_pins_type PWR_IDLE   = 7'h1E;
    localparam sdis_pins_type IDLE_CMD   = 7'h5E;
    localparam sdis_pins_type IDLE_DQ    = 7'h5C; // no_operation, mask low
    localparam sdis_pins_type PRE_ALL    = 7'h4B;
    localparam sdis_pins_type MODE_SET   = 7'h42;
    localparam sdis_pins_type AUTO_REF   = 7'h46;
    localparam sdis_pins_type SELF_IN    = 7'h06;
    localparam sdis_pins_type EXIT_DESEL = 7'h7E;
    localparam sdis_pins_type JUNK_A     = 7'h01; // cke low, other pins noisy
    localparam sdis_pins_type JUNK_B     = 7'h2B; // cke low, other pins noisy

    initial pins = PWR_IDLE;

    // one command per rising edge
    task automatic drive(input sdis_pins_type p);
        @(posedge ref_clk);
        pins <= p;
    endtask

    // waits filled with no_operation
    task automatic idle(input int n);
        repeat (n) drive(IDLE_CMD);
    endtask

    // burst refresh sweep, spaced a row cycle apart
    task automatic burst_refresh();
        repeat (REFRESH_ROWS) begin
            drive(AUTO_REF);
            idle(2);
        end
    endtask

    // hold cke low while the clock settles, then raise it
    task automatic power_up();
        repeat (STABLE_CYCLES) drive(PWR_IDLE);
        drive(IDLE_CMD);
    endtask
endmodule // sdis_ctrl_model

// ==== testbench/tb.sv ====
// self-checking bench for the power-up and self-refresh sequencer
// assumes sdis_pkg and the controller model are compiled first
`timescale 1ns/1ns
module tb;
    import sdis_pkg::*;
    logic              ref_clk = 1'b0; // 50 MHz
    logic              rstn    = 1'b0; // reset, active low
    sdis_pins_type     pins;           // command pins
    logic              initDone;       // init complete
    logic              selfRef;        // in self-refresh
    logic              tick;           // internal refresh pulse
    logic [ROW_W-1:0]  row;            // next refresh row
    logic              dqHighZ;        // data lines released
    int                error_cnt = 0;
    int                compares  = 0;

    always #10 ref_clk = ~ref_clk;

    sdis_ctrl_model sdis_ctrl_model_i (.ref_clk(ref_clk), .pins(pins));
    sdis_core sdis_core_i (.ref_clk(ref_clk), .rstn(rstn), .pins(pins),
        .initDone_q(initDone), .selfRefresh_q(selfRef), .refreshTick_q(tick),
        .refreshRow_q(row), .dqHighZ_q(dqHighZ));

    // compare and count
    task automatic check(input string what, input logic [11:0] seen,
                         input logic [11:0] exp);
        #1;
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // let one edge's updates land
    task automatic settle();
        @(posedge ref_clk);
        #1;
    endtask

    // out-of-order commands are ignored, then the proper sequence completes
    task automatic test_init();
        sdis_ctrl_model_i.power_up();
        sdis_ctrl_model_i.drive(sdis_ctrl_model_i.MODE_SET);
        sdis_ctrl_model_i.idle(2);
        sdis_ctrl_model_i.drive(sdis_ctrl_model_i.AUTO_REF);
        sdis_ctrl_model_i.idle(3);
        sdis_ctrl_model_i.drive(sdis_ctrl_model_i.AUTO_REF);
        sdis_ctrl_model_i.idle(3);
        sdis_ctrl_model_i.drive(sdis_ctrl_model_i.SELF_IN);
        sdis_ctrl_model_i.idle(2);
        check("initDone no precharge", 12'(initDone), 12'h0);
        check("selfRefresh before init", 12'(selfRef), 12'h0);
        check("dqHighZ in init", 12'(dqHighZ), 12'h1);
        sdis_ctrl_model_i.drive(sdis_ctrl_model_i.PRE_ALL);
        sdis_ctrl_model_i.idle(1);
        sdis_ctrl_model_i.drive(sdis_ctrl_model_i.AUTO_REF);
        sdis_ctrl_model_i.idle(3);
        sdis_ctrl_model_i.drive(sdis_ctrl_model_i.AUTO_REF);
        sdis_ctrl_model_i.idle(3);
        check("initDone no mode set", 12'(initDone), 12'h0);
        sdis_ctrl_model_i.drive(sdis_ctrl_model_i.MODE_SET);
        sdis_ctrl_model_i.idle(2);
        sdis_ctrl_model_i.drive(sdis_ctrl_model_i.AUTO_REF);
        sdis_ctrl_model_i.idle(3);
        check("initDone one refresh", 12'(initDone), 12'h0);
        sdis_ctrl_model_i.drive(sdis_ctrl_model_i.AUTO_REF);
        check("initDone at sample", 12'(initDone), 12'h0);
        settle();
        check("initDone after two", 12'(initDone), 12'h1);
    endtask

    // entry, noisy residency with one internal refresh, exit
    task automatic test_self_refresh();
        int n;
        n = 0;
        sdis_ctrl_model_i.burst_refresh();
        sdis_ctrl_model_i.drive(sdis_ctrl_model_i.SELF_IN);
        sdis_ctrl_model_i.drive(sdis_ctrl_model_i.JUNK_A);
        settle();
        check("selfRefresh entry", 12'(selfRef), 12'h1);
        while (tick !== 1'b1 && n < 900) begin
            sdis_ctrl_model_i.drive(n[0] ? sdis_ctrl_model_i.JUNK_A
                                         : sdis_ctrl_model_i.JUNK_B);
            #1;
            n++;
        end
        check("tick spacing", 12'(n >= 775 && n <= 790), 12'h1);
        check("dqHighZ in self-refresh", 12'(dqHighZ), 12'h1);
        settle();
        check("refresh row", row, 12'h001);
        check("still self-refresh", 12'(selfRef), 12'h1);
        sdis_ctrl_model_i.drive(sdis_ctrl_model_i.EXIT_DESEL);
        check("exit at sample", 12'(selfRef), 12'h1);
        settle();
        check("exit done", 12'(selfRef), 12'h0);
        check("init kept", 12'(initDone), 12'h1);
        sdis_ctrl_model_i.idle(4);
        sdis_ctrl_model_i.burst_refresh();
        check("ready after burst", 12'(selfRef), 12'h0);
        sdis_ctrl_model_i.drive(sdis_ctrl_model_i.IDLE_DQ);
        settle();
        settle();
        check("dqHighZ ready mask low", 12'(dqHighZ), 12'h0);
    endtask

    // watchdog
    initial begin
        #(60000 * 20);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        test_init();
        test_self_refresh();
        tally_and_finish();
    end
endmodule // tb
